/* dccc_pkg.sv */
// Register map, fields, reset values and types of the command block.
package dccc_pkg;

    // Register addresses.
    localparam logic [7:0]  DCCC_ADDR_NODE_ADDRESS   = 8'h0A;
    localparam logic [7:0]  DCCC_ADDR_DEVICE_COMMAND = 8'h0C;
    localparam logic [7:0]  DCCC_ADDR_CHANNEL_COUNT  = 8'h0D;
    localparam logic [7:0]  DCCC_ADDR_DEVICE_CONFIG  = 8'h0E;
    localparam logic [7:0]  DCCC_ADDR_KEY_A_BASE     = 8'h80;
    localparam logic [7:0]  DCCC_ADDR_KEY_B_BASE     = 8'h84;

    // Command bit positions in device_command.
    localparam int          DCCC_BIT_SELF_RESET      = 7;
    localparam int          DCCC_BIT_SHUTDOWN        = 6;
    localparam int          DCCC_BIT_UP_WAKE         = 5;
    localparam int          DCCC_BIT_NVM_PROGRAM     = 4;
    localparam int          DCCC_BIT_ADDR_ASSIGN     = 3;

    // Address source bit in device_config.
    localparam int          DCCC_BIT_ADDR_SOURCE     = 4;

    // Field widths.
    localparam int          DCCC_ADDR_W              = 5;
    localparam int          DCCC_COUNT_W             = 5;
    localparam int          DCCC_CHANNELS            = 16;

    // Unlock key values needed for a save.
    localparam logic [31:0] DCCC_KEY_A_VALUE         = 32'h8C2D_B194;
    localparam logic [31:0] DCCC_KEY_B_VALUE         = 32'hA375_E60F;

    // Values after reset.
    localparam logic [4:0]  DCCC_RST_NODE_ADDRESS    = 5'h00;
    localparam logic [4:0]  DCCC_RST_CHANNEL_COUNT   = 5'h10;
    localparam logic        DCCC_RST_ADDR_SOURCE     = 1'b0;
    localparam logic [31:0] DCCC_RST_KEY             = 32'h0000_0000;
    localparam logic [7:0]  DCCC_RST_RDATA           = 8'h00;

    // Channel count and idle channel limits.
    localparam logic [4:0]  DCCC_MAX_CHANNEL_COUNT   = 5'h10;
    localparam logic [4:0]  DCCC_IDLE_WHEN_ZERO      = 5'h01;

    // State of a long-running operation.
    typedef enum logic {
        DCCC_OP_IDLE,
        DCCC_OP_BUSY
    } dccc_op_state_t;

endpackage : dccc_pkg

/* dccc_ctrl.sv */
// Command and channel configuration register block of a stackable cell monitor.
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/10ps

// Functional notes
// R1: Self reset command reinitializes, reads zero.
// R2: Shutdown command powers the device down.
// R3: Upstream wake bit sends tone upward.
// R4: Block upward traffic until wake completes.
// R5: Wake bit reads one during tone.
// R6: Nonvolatile save only with both keys matching.
// R7: Program bit reads one during cycle.
// R8: Host handles short powerdown period before save.
// R9: Host avoids writes and shutdown while programming.
// R10: GPIO source: assign samples pins, reads zero.
// R11: Auto source: assign enters auto addressing.
// R12: Auto assign clears after next received frame.
// R13: Host writes zero to reserved bits.
// R14: Channel count drops channels from sixteen down.
// R15: Idle multiplexer channel equals channel count.
// R16: Count zero makes idle channel input one.
// R17: Mask faults, disable comparators beyond count.
// R18: Host never programs count above sixteen.
// R19: Node address writable only during auto assign.
// R20: Source select: zero GPIO, one auto.
// R21: Writing zero to command bits does nothing.
// R22: Unkeyed program write ignored, reads zero.

module dccc_ctrl
    import dccc_pkg::*;
#(
    parameter int CHANNELS = DCCC_CHANNELS
) (
    input  wire logic                  ref_clk,            // Clock.
    input  wire logic                  resetn,             // Reset, active low.
    input  wire logic                  clk_en,             // Low freezes all state.
    input  wire logic [7:0]            reg_addr,           // Register address.
    input  wire logic [7:0]            reg_wdata,          // Write data.
    input  wire logic                  reg_wr,             // Write strobe.
    input  wire logic                  reg_rd,             // Read strobe.
    output logic      [7:0]            reg_rdata,          // Read data, one cycle late.
    input  wire logic                  frame_received,     // Frame end pulse.
    input  wire logic [DCCC_ADDR_W-1:0] gpio_addr_pins,    // Address pins.
    input  wire logic                  wake_tone_done,     // Wake tone end pulse.
    input  wire logic                  nvm_program_done,   // Save end pulse.
    input  wire logic [CHANNELS-1:0]   ov_fault_raw,       // Raw overvoltage.
    input  wire logic [CHANNELS-1:0]   uv_fault_raw,       // Raw undervoltage.
    output logic                       self_reset_pulse,   // Restart pulse.
    output logic                       shutdown_req,       // Power-down request.
    output logic                       wake_tone_start,    // Wake tone start.
    output logic                       upstream_block,     // Upward traffic held.
    output logic                       nvm_program_start,  // Save start.
    output logic                       nvm_busy,           // Save running.
    output logic                       auto_addr_mode,     // Auto addressing on.
    output logic [DCCC_ADDR_W-1:0]     node_address,       // Node address.
    output logic [DCCC_COUNT_W-1:0]    idle_channel,       // Idle channel.
    output logic [CHANNELS-1:0]        comparator_enable,  // Comparator enables.
    output logic [CHANNELS-1:0]        ov_fault_masked,    // Active overvoltage.
    output logic [CHANNELS-1:0]        uv_fault_masked     // Active undervoltage.
);

    // Address decoders.
    function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
        addr_hit = (addr == target);
    endfunction : addr_hit

    function automatic logic key_hit(input logic [7:0] addr, input logic [7:0] base);
        key_hit = (addr[7:2] == base[7:2]);
    endfunction : key_hit

    logic                     soft_clear_reg;
    logic [DCCC_COUNT_W-1:0]  channel_count_reg;
    logic                     addr_source_reg;
    logic [DCCC_ADDR_W-1:0]   node_address_reg;
    logic                     auto_mode_reg;

    logic [31:0]              key_a_reg;
    logic [31:0]              key_b_reg;

    dccc_op_state_t           wake_state_reg;
    dccc_op_state_t           nvm_state_reg;

    logic [7:0]               rdata_next;
    logic [DCCC_COUNT_W-1:0]  clamped_count;
    logic [CHANNELS-1:0]      enable_next;

    logic wr_cmd;
    logic wr_count;
    logic wr_config;
    logic wr_node;

    logic keys_match;
    logic wake_go;
    logic nvm_go;
    logic assign_go;

    assign wr_cmd     = reg_wr && addr_hit(reg_addr, DCCC_ADDR_DEVICE_COMMAND);
    assign wr_count   = reg_wr && addr_hit(reg_addr, DCCC_ADDR_CHANNEL_COUNT);
    assign wr_config  = reg_wr && addr_hit(reg_addr, DCCC_ADDR_DEVICE_CONFIG);
    assign wr_node    = reg_wr && addr_hit(reg_addr, DCCC_ADDR_NODE_ADDRESS);

    assign keys_match = (key_a_reg == DCCC_KEY_A_VALUE) && (key_b_reg == DCCC_KEY_B_VALUE);

    // Only a one starts a command, so a zero never cancels a running operation.
    assign wake_go   = wr_cmd && reg_wdata[DCCC_BIT_UP_WAKE]; // R21
    // A program write while busy is dropped, not restarted.
    assign nvm_go    = wr_cmd && reg_wdata[DCCC_BIT_NVM_PROGRAM] && keys_match // R6 R22
                       && (nvm_state_reg == DCCC_OP_IDLE);
    assign assign_go = wr_cmd && reg_wdata[DCCC_BIT_ADDR_ASSIGN]; // R21

    // Self reset clears the registers one cycle after the write,
    // beside the pulse that restarts initialization.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            soft_clear_reg   <= 1'b0;
            self_reset_pulse <= 1'b0;
        end else if (clk_en) begin
            soft_clear_reg   <= wr_cmd && reg_wdata[DCCC_BIT_SELF_RESET]; // R1
            self_reset_pulse <= wr_cmd && reg_wdata[DCCC_BIT_SELF_RESET]; // R1
        end
    end

    // Shutdown is held until the device loses power or is reset.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            shutdown_req <= 1'b0;
        end else if (clk_en) begin
            if (soft_clear_reg) begin
                shutdown_req <= 1'b0;
            end else if (wr_cmd && reg_wdata[DCCC_BIT_SHUTDOWN]) begin
                shutdown_req <= 1'b1; // R2
            end
        end
    end

    // Upward wake tone sequencing.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            wake_state_reg  <= DCCC_OP_IDLE;
            wake_tone_start <= 1'b0;
            upstream_block  <= 1'b0;
        end else if (clk_en) begin
            wake_tone_start <= 1'b0;
            case (wake_state_reg)
                DCCC_OP_IDLE: begin
                    if (wake_go && !soft_clear_reg) begin
                        wake_state_reg  <= DCCC_OP_BUSY; // R3
                        wake_tone_start <= 1'b1; // R3
                        upstream_block  <= 1'b1; // R4
                    end
                end
                DCCC_OP_BUSY: begin
                    if (wake_tone_done || soft_clear_reg) begin
                        wake_state_reg <= DCCC_OP_IDLE; // R5
                        upstream_block <= 1'b0; // R4
                    end
                end
                default: begin
                    wake_state_reg <= DCCC_OP_IDLE;
                    upstream_block <= 1'b0;
                end
            endcase
        end
    end

    // Save sequencing; a self reset does not abort a running save.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            nvm_state_reg     <= DCCC_OP_IDLE;
            nvm_program_start <= 1'b0;
            nvm_busy          <= 1'b0;
        end else if (clk_en) begin
            nvm_program_start <= 1'b0;
            case (nvm_state_reg)
                DCCC_OP_IDLE: begin
                    if (nvm_go && !soft_clear_reg) begin
                        nvm_state_reg     <= DCCC_OP_BUSY; // R6
                        nvm_program_start <= 1'b1; // R6
                        nvm_busy          <= 1'b1; // R7
                    end
                end
                DCCC_OP_BUSY: begin
                    if (nvm_program_done) begin
                        nvm_state_reg <= DCCC_OP_IDLE; // R7
                        nvm_busy      <= 1'b0; // R7
                    end
                end
                default: begin
                    nvm_state_reg <= DCCC_OP_IDLE;
                    nvm_busy      <= 1'b0;
                end
            endcase
        end
    end

    // Source select never alters the node address.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            addr_source_reg <= DCCC_RST_ADDR_SOURCE;
        end else if (clk_en) begin
            if (soft_clear_reg) begin
                addr_source_reg <= DCCC_RST_ADDR_SOURCE;
            end else if (wr_config) begin
                addr_source_reg <= reg_wdata[DCCC_BIT_ADDR_SOURCE]; // R20
            end
        end
    end

    // Auto mode; an assign beside a frame end wins.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            auto_mode_reg <= 1'b0;
        end else if (clk_en) begin
            if (soft_clear_reg) begin
                auto_mode_reg <= 1'b0;
            end else if (assign_go && addr_source_reg) begin
                auto_mode_reg <= 1'b1; // R11
            end else if (frame_received) begin
                auto_mode_reg <= 1'b0; // R12
            end
        end
    end

    // Node address: from the pins, or host-written in auto mode.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            node_address_reg <= DCCC_RST_NODE_ADDRESS;
        end else if (clk_en) begin
            if (soft_clear_reg) begin
                node_address_reg <= DCCC_RST_NODE_ADDRESS;
            end else if (assign_go && !addr_source_reg) begin
                node_address_reg <= gpio_addr_pins; // R10
            end else if (wr_node && auto_mode_reg) begin
                node_address_reg <= reg_wdata[DCCC_ADDR_W-1:0]; // R19
            end
        end
    end

    // Unlock keys, one byte per address, low byte at the base.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            key_a_reg <= DCCC_RST_KEY;
            key_b_reg <= DCCC_RST_KEY;
        end else if (clk_en) begin
            if (soft_clear_reg) begin
                key_a_reg <= DCCC_RST_KEY;
                key_b_reg <= DCCC_RST_KEY;
            end else if (reg_wr) begin
                for (int i = 0; i < 4; i++) begin
                    if (key_hit(reg_addr, DCCC_ADDR_KEY_A_BASE) && (reg_addr[1:0] == 2'(i))) begin
                        key_a_reg[8*i +: 8] <= reg_wdata;
                    end
                    if (key_hit(reg_addr, DCCC_ADDR_KEY_B_BASE) && (reg_addr[1:0] == 2'(i))) begin
                        key_b_reg[8*i +: 8] <= reg_wdata;
                    end
                end
            end
        end
    end

    // Channel count; reserved upper bits are not stored.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            channel_count_reg <= DCCC_RST_CHANNEL_COUNT;
        end else if (clk_en) begin
            if (soft_clear_reg) begin
                channel_count_reg <= DCCC_RST_CHANNEL_COUNT;
            end else if (wr_count) begin
                channel_count_reg <= reg_wdata[DCCC_COUNT_W-1:0]; // R14
            end
        end
    end

    // Reserved counts above sixteen act as sixteen.
    always_comb begin
        clamped_count = (channel_count_reg > DCCC_MAX_CHANNEL_COUNT) ? DCCC_MAX_CHANNEL_COUNT
                                                                     : channel_count_reg;
    end

    // Channels are kept from the lowest upward, so the top ones drop first.
    generate
        for (genvar g = 0; g < CHANNELS; g++) begin : g_chan
            assign enable_next[g] = (DCCC_COUNT_W'(g) < clamped_count); // R14
        end
    endgenerate

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            comparator_enable <= '0;
            ov_fault_masked   <= '0;
            uv_fault_masked   <= '0;
            idle_channel      <= DCCC_IDLE_WHEN_ZERO;
        end else if (clk_en) begin
            comparator_enable <= enable_next; // R17
            ov_fault_masked   <= ov_fault_raw & enable_next; // R17
            uv_fault_masked   <= uv_fault_raw & enable_next; // R17
            if (clamped_count == '0) begin
                idle_channel <= DCCC_IDLE_WHEN_ZERO; // R16
            end else begin
                idle_channel <= clamped_count; // R15
            end
        end
    end

    // Read mux; self reset and shutdown read zero.
    always_comb begin
        rdata_next = DCCC_RST_RDATA;
        if (addr_hit(reg_addr, DCCC_ADDR_DEVICE_COMMAND)) begin
            rdata_next[DCCC_BIT_UP_WAKE]     = (wake_state_reg == DCCC_OP_BUSY); // R5
            rdata_next[DCCC_BIT_NVM_PROGRAM] = (nvm_state_reg == DCCC_OP_BUSY); // R7 R22
            rdata_next[DCCC_BIT_ADDR_ASSIGN] = auto_mode_reg; // R10 R12
        end else if (addr_hit(reg_addr, DCCC_ADDR_CHANNEL_COUNT)) begin
            rdata_next[DCCC_COUNT_W-1:0] = channel_count_reg;
        end else if (addr_hit(reg_addr, DCCC_ADDR_DEVICE_CONFIG)) begin
            rdata_next[DCCC_BIT_ADDR_SOURCE] = addr_source_reg;
        end else if (addr_hit(reg_addr, DCCC_ADDR_NODE_ADDRESS)) begin
            rdata_next[DCCC_ADDR_W-1:0] = node_address_reg;
        end else if (key_hit(reg_addr, DCCC_ADDR_KEY_A_BASE)) begin
            rdata_next = key_a_reg[8*reg_addr[1:0] +: 8];
        end else if (key_hit(reg_addr, DCCC_ADDR_KEY_B_BASE)) begin
            rdata_next = key_b_reg[8*reg_addr[1:0] +: 8];
        end
    end

    // Read data stands in each cycle after a cycle with reg_rd high and is zero otherwise.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= DCCC_RST_RDATA;
        end else if (clk_en) begin
            reg_rdata <= reg_rd ? rdata_next : DCCC_RST_RDATA;
        end
    end

    // Registered copies driven straight out.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            auto_addr_mode <= 1'b0;
            node_address   <= DCCC_RST_NODE_ADDRESS;
        end else if (clk_en) begin
            auto_addr_mode <= auto_mode_reg;
            node_address   <= node_address_reg;
        end
    end

endmodule : dccc_ctrl

/* dccc_ctrl_monitor.sv */
// Port checker for the command block.
`timescale 1ns/10ps
module dccc_ctrl_monitor
    import dccc_pkg::*;
#(
    parameter int CHANNELS = DCCC_CHANNELS
) (
    input wire logic                    ref_clk,           // Clock.
    input wire logic                    resetn,            // Reset, active low.
    input wire logic [7:0]              reg_addr,          // Register address.
    input wire logic [7:0]              reg_wdata,         // Write data.
    input wire logic                    reg_wr,            // Write strobe.
    input wire logic                    self_reset_pulse,  // Reinitialize request.
    input wire logic                    shutdown_req,      // Power-down request.
    input wire logic                    wake_tone_start,   // Wake tone start.
    input wire logic                    upstream_block,    // Upward traffic hold-off.
    input wire logic                    wake_tone_done,    // Wake tone end.
    input wire logic                    nvm_program_start, // Save start.
    input wire logic                    nvm_busy,          // Save running.
    input wire logic                    nvm_program_done,  // Save end.
    input wire logic [DCCC_COUNT_W-1:0] idle_channel,      // Idle channel.
    input wire logic [CHANNELS-1:0]     comparator_enable  // Comparator enables.
);
    logic cmd_wr;
    logic nvm_wr;
    assign cmd_wr = reg_wr && reg_addr == DCCC_ADDR_DEVICE_COMMAND;
    assign nvm_wr = cmd_wr && reg_wdata[DCCC_BIT_NVM_PROGRAM];

    function automatic logic [4:0] idle_of(input logic [7:0] v);
        return (v[4:0] == 5'h00) ? DCCC_IDLE_WHEN_ZERO : ((v[4:0] > 5'h10) ? 5'h10 : v[4:0]);
    endfunction : idle_of

    // Counts above sixteen are clamped, so the shift never runs past the mask.
    function automatic logic [CHANNELS-1:0] mask_of(input logic [7:0] v);
        return (v[4:0] >= 5'h10) ? {CHANNELS{1'h1}} : CHANNELS'((32'h0000_0001 << v[4:0]) - 32'h0000_0001);
    endfunction : mask_of

    sequence s_cnt_wr;
        reg_wr && reg_addr == DCCC_ADDR_CHANNEL_COUNT;
    endsequence
    sequence s_wake_req;
        cmd_wr && reg_wdata[DCCC_BIT_UP_WAKE] && !reg_wdata[DCCC_BIT_SELF_RESET] && !upstream_block;
    endsequence

    default clocking dccc_cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    a_reset_pulse: assert property (cmd_wr && reg_wdata[7] |=> self_reset_pulse ##1 !self_reset_pulse)
        else $error("self reset pulse wrong");
    a_shutdown_held: assert property (cmd_wr && reg_wdata[6] && !reg_wdata[7] |=> shutdown_req [*2])
        else $error("shutdown request missing");
    a_wake_start: assert property (s_wake_req |=> wake_tone_start && upstream_block)
        else $error("wake tone did not start");
    a_wake_release: assert property ($fell(upstream_block) |-> $past(wake_tone_done) || $past(self_reset_pulse))
        else $error("upward hold-off ended early");
    a_nvm_cause: assert property (nvm_program_start |-> nvm_busy && $past(nvm_wr))
        else $error("save started without request");
    a_nvm_hold: assert property (nvm_busy && !nvm_program_done |=> nvm_busy)
        else $error("save busy dropped early");
    a_zero_cmd: assert property (cmd_wr && reg_wdata == 8'h00 |=> !(wake_tone_start || nvm_program_start || self_reset_pulse))
        else $error("zero command had an effect");
    a_idle_track: assert property (s_cnt_wr |-> ##2 idle_channel == idle_of($past(reg_wdata, 2)))
        else $error("idle channel wrong");
    a_mask_track: assert property (s_cnt_wr |-> ##2 comparator_enable == mask_of($past(reg_wdata, 2)))
        else $error("comparator enables wrong");
endmodule : dccc_ctrl_monitor

bind dccc_ctrl dccc_ctrl_monitor #(.CHANNELS(CHANNELS)) dccc_ctrl_monitor_i (
    .ref_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .self_reset_pulse, .shutdown_req, .wake_tone_start,
    .upstream_block, .wake_tone_done, .nvm_program_start, .nvm_busy, .nvm_program_done, .idle_channel,
    .comparator_enable
);

/* dccc_far_model.sv */
// Outside sequencers that finish wake tones and saves.
`timescale 1ns/10ps
module dccc_far_model (
    input  wire logic       ref_clk,           // Clock.
    input  wire logic       resetn,            // Reset, active low.
    input  wire logic [7:0] delay,             // Cycles from start to done, at least one.
    input  wire logic       wake_tone_start,   // Wake tone start.
    input  wire logic       nvm_program_start, // Save start.
    output logic            wake_tone_done,    // Wake tone end pulse.
    output logic            nvm_program_done   // Save end pulse.
);
    int wcnt;
    int ncnt;
    // A long delay stands in for a tall stack that is slow to wake.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            wcnt <= 0;
            ncnt <= 0;
        end else begin
            wcnt <= wake_tone_start ? int'(delay) : ((wcnt != 0) ? wcnt - 1 : 0);
            ncnt <= nvm_program_start ? int'(delay) : ((ncnt != 0) ? ncnt - 1 : 0);
        end
    end
    assign wake_tone_done   = (wcnt == 1);
    assign nvm_program_done = (ncnt == 1);
endmodule : dccc_far_model

/* dccc_ctrl_tb.sv */
// Self-checking bench for the command block.
`timescale 1ns/10ps
module dccc_ctrl_tb import dccc_pkg::*; ;
    logic        ref_clk = 1'h0;
    logic        resetn = 1'h0;
    logic        clk_en = 1'h1;
    logic [7:0]  reg_addr = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'h0;
    logic        reg_rd = 1'h0;
    logic        frame_received = 1'h0;
    logic [4:0]  gpio_addr_pins = 5'h00;
    logic [15:0] ov_fault_raw = 16'h0000;
    logic [15:0] uv_fault_raw = 16'h0000;
    logic [7:0]  delay = 8'h01;
    logic [7:0]  reg_rdata;
    logic        self_reset_pulse, shutdown_req, wake_tone_start, upstream_block, nvm_program_start;
    logic        nvm_busy, auto_addr_mode, wake_tone_done, nvm_program_done;
    logic [4:0]  node_address, idle_channel;
    logic [15:0] comparator_enable, ov_fault_masked, uv_fault_masked;
    int          n_mismatch = 0;
    int          checks_done = 0;
    int          cyc = 0;

    dccc_ctrl dccc_ctrl_i (
        .ref_clk, .resetn, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .frame_received,
        .gpio_addr_pins, .wake_tone_done, .nvm_program_done, .ov_fault_raw, .uv_fault_raw, .self_reset_pulse,
        .shutdown_req, .wake_tone_start, .upstream_block, .nvm_program_start, .nvm_busy, .auto_addr_mode,
        .node_address, .idle_channel, .comparator_enable, .ov_fault_masked, .uv_fault_masked);
    dccc_far_model dccc_far_model_i (
        .ref_clk, .resetn, .delay, .wake_tone_start, .nvm_program_start, .wake_tone_done, .nvm_program_done);

    always #5 ref_clk = ~ref_clk;

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : summarize

    // The run needs under a thousand cycles.
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            summarize();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr    <= 1'h1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr    <= 1'h0;
    endtask : wr

    // Read data stand only in the cycle after the strobe.
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_rd   <= 1'h1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd   <= 1'h0;
        #1;
        chk(16'(reg_rdata), 16'(exp), "read");
    endtask : rd

    task automatic wkey(input logic [7:0] base, input logic [31:0] k);
        for (int i = 0; i < 4; i++) begin
            wr(base + 8'(i), k[8*i +: 8]);
        end
    endtask : wkey

    task automatic wait_idle();
        for (int i = 0; i < 100 && (upstream_block !== 1'h0 || nvm_busy !== 1'h0); i++) begin
            @(posedge ref_clk);
        end
        #1;
        chk(16'({upstream_block, nvm_busy}), 16'h0000, "operation end");
    endtask : wait_idle

    function automatic logic [15:0] mask_of(input logic [4:0] v);
        return (v >= 5'h10) ? 16'hFFFF : 16'((17'h1 << v) - 17'h1);
    endfunction : mask_of

    initial begin
        logic [4:0] v;
        logic [4:0] p;
        v = 5'($urandom(32'h11e5));
        repeat (3) @(posedge ref_clk);
        resetn <= 1'h1;
        rd(DCCC_ADDR_CHANNEL_COUNT, 8'h10);
        chk(comparator_enable, 16'hFFFF, "reset enables");
        wr(8'h33, 8'hFF);
        rd(8'h33, 8'h00);
        for (int i = 0; i < 10; i++) begin
            v = (i < 3) ? 5'(i * 8) : 5'($urandom_range(16));
            @(posedge ref_clk);
            ov_fault_raw <= 16'($urandom);
            uv_fault_raw <= 16'($urandom);
            wr(DCCC_ADDR_CHANNEL_COUNT, {3'h0, v});
            repeat (2) @(posedge ref_clk);
            #1;
            chk(16'(idle_channel), 16'((v == 5'h00) ? 5'h01 : v), "idle channel");
            chk(comparator_enable, mask_of(v), "enables");
            chk(ov_fault_masked, ov_fault_raw & mask_of(v), "ov mask");
            chk(uv_fault_masked, uv_fault_raw & mask_of(v), "uv mask");
            rd(DCCC_ADDR_CHANNEL_COUNT, {3'h0, v});
        end
        delay <= 8'($urandom_range(30, 10));
        wr(DCCC_ADDR_DEVICE_COMMAND, 8'h20);
        #1;
        chk(16'({wake_tone_start, upstream_block}), 16'h0003, "wake start");
        wr(DCCC_ADDR_DEVICE_COMMAND, 8'h00);
        rd(DCCC_ADDR_DEVICE_COMMAND, 8'h20);
        chk(16'(upstream_block), 16'h0001, "hold-off");
        wait_idle();
        rd(DCCC_ADDR_DEVICE_COMMAND, 8'h00);
        wr(DCCC_ADDR_DEVICE_COMMAND, 8'h10);
        rd(DCCC_ADDR_DEVICE_COMMAND, 8'h00);
        wkey(DCCC_ADDR_KEY_A_BASE, DCCC_KEY_A_VALUE);
        wkey(DCCC_ADDR_KEY_B_BASE, DCCC_KEY_B_VALUE ^ 32'h0000_0001);
        wr(DCCC_ADDR_DEVICE_COMMAND, 8'h10);
        rd(DCCC_ADDR_DEVICE_COMMAND, 8'h00);
        wkey(DCCC_ADDR_KEY_B_BASE, DCCC_KEY_B_VALUE);
        delay <= 8'h01;
        wr(DCCC_ADDR_DEVICE_COMMAND, 8'h10);
        #1;
        chk(16'({nvm_program_start, nvm_busy}), 16'h0003, "save start");
        wait_idle();
        rd(DCCC_ADDR_DEVICE_COMMAND, 8'h00);
        p = 5'($urandom);
        @(posedge ref_clk);
        gpio_addr_pins <= p;
        wr(DCCC_ADDR_DEVICE_COMMAND, 8'h08);
        rd(DCCC_ADDR_DEVICE_COMMAND, 8'h00);
        wr(DCCC_ADDR_NODE_ADDRESS, {3'h0, ~p});
        rd(DCCC_ADDR_NODE_ADDRESS, {3'h0, p});
        chk(16'(node_address), 16'(p), "pin address");
        wr(DCCC_ADDR_DEVICE_CONFIG, 8'h10);
        rd(DCCC_ADDR_NODE_ADDRESS, {3'h0, p});
        wr(DCCC_ADDR_DEVICE_COMMAND, 8'h08);
        rd(DCCC_ADDR_DEVICE_COMMAND, 8'h08);
        chk(16'(auto_addr_mode), 16'h0001, "auto mode");
        wr(DCCC_ADDR_NODE_ADDRESS, {3'h0, ~p});
        rd(DCCC_ADDR_NODE_ADDRESS, {3'h0, ~p});
        @(posedge ref_clk);
        frame_received <= 1'h1;
        @(posedge ref_clk);
        frame_received <= 1'h0;
        rd(DCCC_ADDR_DEVICE_COMMAND, 8'h00);
        chk(16'(auto_addr_mode), 16'h0000, "auto end");
        wr(DCCC_ADDR_DEVICE_COMMAND, 8'h40);
        rd(DCCC_ADDR_DEVICE_COMMAND, 8'h00);
        chk(16'(shutdown_req), 16'h0001, "shutdown");
        wr(DCCC_ADDR_DEVICE_COMMAND, 8'h80);
        #1;
        chk(16'(self_reset_pulse), 16'h0001, "self reset");
        rd(DCCC_ADDR_DEVICE_COMMAND, 8'h00);
        chk(16'(shutdown_req), 16'h0000, "shutdown cleared");
        rd(DCCC_ADDR_CHANNEL_COUNT, 8'h10);
        rd(DCCC_ADDR_DEVICE_CONFIG, 8'h00);
        rd(DCCC_ADDR_NODE_ADDRESS, 8'h00);
        summarize();
    end
endmodule : dccc_ctrl_tb
